// >>> rtl/rhps_pkg.sv
// constants shared by the root hub port state logic
// assumes a 32-bit apb register bus and one clock domain
package rhps_pkg;

   // register byte offsets
   localparam logic [7:0] PORT_REG_OFFSET   = 8'h00;
   localparam logic [7:0] IRQ_STATUS_OFFSET = 8'h04;
   localparam logic [7:0] IRQ_CLEAR_OFFSET  = 8'h08;
   localparam logic [7:0] IRQ_ENABLE_OFFSET = 8'h0c;

   // port register bit positions
   localparam int unsigned ATTACHED_BIT   = 0;
   localparam int unsigned DISABLE_BIT    = 0;
   localparam int unsigned ENABLED_BIT    = 1;
   localparam int unsigned SUSPENDED_BIT  = 2;
   localparam int unsigned RESUME_REQ_BIT = 3;
   localparam int unsigned RESET_BIT      = 4;

   // interrupt event positions
   localparam int unsigned EV_CONNECT  = 0;
   localparam int unsigned EV_ENABLE   = 1;
   localparam int unsigned EV_SUSPEND  = 2;
   localparam int unsigned EV_RESET    = 3;
   localparam int unsigned EV_RESUME   = 4;
   localparam int unsigned EVENT_COUNT = 5;

   // values after reset
   localparam logic [EVENT_COUNT-1:0] IRQ_STATUS_RESET = 5'h00;
   localparam logic [EVENT_COUNT-1:0] IRQ_ENABLE_RESET = 5'h00;
   localparam logic [31:0]            RDATA_RESET      = 32'h0000_0000;

endpackage : rhps_pkg

// >>> rtl/rhps_reg_if.sv
// register access carrier between the apb slave, the port core
// and the interrupt unit; assumes one clock domain
interface rhps_reg_if #(
   parameter int AW = 8,
   parameter int EW = 5
);
   logic          wr_en;
   logic [AW-1:0] addr;
   logic [31:0]   wdata;
   logic [31:0]   port_value;
   logic [EW-1:0] irq_status;
   logic [EW-1:0] irq_enable;

   modport slave (output wr_en, addr, wdata,
                  input  port_value, irq_status, irq_enable);
   modport core  (input  wr_en, addr, wdata,
                  output port_value);
   modport irq   (input  wr_en, addr, wdata,
                  output irq_status, irq_enable);
endinterface : rhps_reg_if

// >>> rtl/rhps_apb_slave.sv
// apb slave: decode, write strobe and registered read data
// assumes the master keeps the request stable through the access
module rhps_apb_slave
   import rhps_pkg::*;
#(
   parameter int AW = 8
)(
   input  wire logic          clk_in,
   input  wire logic          nrst_in,
   input  wire logic          psel_in,
   input  wire logic          penable_in,
   input  wire logic          pwrite_in,
   input  wire logic [AW-1:0] paddr_in,
   input  wire logic [31:0]   pwdata_in,
   output logic [31:0]        prdata_out,
   output logic               pready_out,
   output logic               pslverr_out,
   rhps_reg_if.slave          rif
);
   logic [31:0] prdata_ff;
   logic [31:0] nxt_prdata;
   logic        mapped;
   logic        access;

   assign access = psel_in & penable_in;
   assign mapped = (paddr_in == AW'(PORT_REG_OFFSET))
                 | (paddr_in == AW'(IRQ_STATUS_OFFSET))
                 | (paddr_in == AW'(IRQ_CLEAR_OFFSET))
                 | (paddr_in == AW'(IRQ_ENABLE_OFFSET));

   // zero wait states, so ready never stalls
   assign pready_out  = 1'b1;
   assign pslverr_out = access & ~mapped;
   assign rif.wr_en   = access & pwrite_in & mapped;
   assign rif.addr    = paddr_in;
   assign rif.wdata   = pwdata_in;
   assign prdata_out  = prdata_ff;

   always_comb
   begin
      nxt_prdata = 32'h0000_0000;
      if (paddr_in == AW'(PORT_REG_OFFSET))
         nxt_prdata = rif.port_value;
      else if (paddr_in == AW'(IRQ_STATUS_OFFSET))
         nxt_prdata = 32'(rif.irq_status);
      else if (paddr_in == AW'(IRQ_ENABLE_OFFSET))
         nxt_prdata = 32'(rif.irq_enable);
   end

   // captured in the setup cycle, stable for the access phase
   always_ff @(posedge clk_in)
   begin
      if (!nrst_in)
         prdata_ff <= RDATA_RESET;
      else if (psel_in & ~penable_in & ~pwrite_in)
         prdata_ff <= nxt_prdata;
   end
endmodule : rhps_apb_slave

// >>> rtl/rhps_irq.sv
// sticky event status, write-one-to-clear, enable mask, level irq
// assumes event inputs are one-cycle pulses from the port core
module rhps_irq
   import rhps_pkg::*;
#(
   parameter int EW = EVENT_COUNT
)(
   input  wire logic          clk_in,
   input  wire logic          nrst_in,
   input  wire logic [EW-1:0] events_in,
   output logic               irq_out,
   rhps_reg_if.irq            rif
);
   logic [EW-1:0] status_ff;
   logic [EW-1:0] enable_ff;
   logic [EW-1:0] clear;

   assign clear = (rif.wr_en && rif.addr == IRQ_CLEAR_OFFSET)
                ? rif.wdata[EW-1:0] : '0;

   // a new event beats a clear in the same cycle
   always_ff @(posedge clk_in)
   begin
      if (!nrst_in)
         status_ff <= IRQ_STATUS_RESET;
      else
         status_ff <= (status_ff & ~clear) | events_in;
   end

   always_ff @(posedge clk_in)
   begin
      if (!nrst_in)
         enable_ff <= IRQ_ENABLE_RESET;
      else if (rif.wr_en && rif.addr == IRQ_ENABLE_OFFSET)
         enable_ff <= rif.wdata[EW-1:0];
   end

   assign rif.irq_status = status_ff;
   assign rif.irq_enable = enable_ff;
   assign irq_out        = |(status_ff & enable_ff);
endmodule : rhps_irq

// >>> rtl/rhps_port_top.sv
// root hub port state: attached, enabled and suspended flags
// assumes all event inputs are synchronous to CLK_IN and
// that the reset and resume sequencers sit outside this block
//
// Our own choices: the address map and register access over APB.

// What this block does
// (R1) Writing 1 to bit 2 suspends an attached port; 0 does nothing.
// (R2) Suspend write on a detached port raises connect change instead.
// (R3) End of resume interval clears suspend and raises suspend change.
// (R4) Reset completion or controller resume also clears suspend.
// (R5) Downstream resume while suspended is passed up as an event.
// (R6) Overcurrent, disconnect, power off or bus error disable port.
// (R7) Such a hardware disable raises the enable change event.
// (R8) Reset completion or resume completion enables the port.
// (R9) Writing 1 to bit 1 enables the port; 0 does nothing.
// (R10) Enable write on a detached port raises connect change instead.
// (R11) Bit 0 reads 1 when a device is attached, else 0.
// (R12) Writing 1 to bit 0 disables the port; 0 does nothing.
// (R13) Attached flag follows the pin or the nonremovable input only, never a write.
// (R14) Nonremovable device makes the attached flag always read 1.
// (R15) Reset write starts reset if attached, else connect change.
// (R16) Updates happen on the clock edge; hardware clear beats set.
module rhps_port_top
   import rhps_pkg::*;
#(
   parameter int AW = 8
)(
   input  wire logic          CLK_IN,
   input  wire logic          NRST_IN,
   input  wire logic          PSEL_IN,
   input  wire logic          PENABLE_IN,
   input  wire logic          PWRITE_IN,
   input  wire logic [AW-1:0] PADDR_IN,
   input  wire logic [31:0]   PWDATA_IN,
   output logic [31:0]        PRDATA_OUT,
   output logic               PREADY_OUT,
   output logic               PSLVERR_OUT,
   input  wire logic          ATTACH_IN,
   input  wire logic          NONREMOVABLE_IN,
   input  wire logic          OVERCURRENT_IN,
   input  wire logic          POWER_OFF_IN,
   input  wire logic          BUS_ERROR_IN,
   input  wire logic          RESET_DONE_IN,
   input  wire logic          RESUME_DONE_IN,
   input  wire logic          CONTROLLER_RESUME_IN,
   input  wire logic          DEVICE_RESUME_IN,
   output logic               DEVICE_ATTACHED_OUT,
   output logic               PORT_ENABLED_OUT,
   output logic               PORT_SUSPENDED_OUT,
   output logic               PORT_RESETTING_OUT,
   output logic               RESET_START_OUT,
   output logic               RESUME_START_OUT,
   output logic               RESUME_EVENT_OUT,
   output logic               CONNECT_CHANGE_OUT,
   output logic               ENABLE_CHANGE_OUT,
   output logic               SUSPEND_CHANGE_OUT,
   output logic               IRQ_OUT
);
   rhps_reg_if #(.AW(AW), .EW(EVENT_COUNT)) rif ();

   logic                   attached_ff;
   logic                   enabled_ff;
   logic                   suspended_ff;
   logic                   resetting_ff;
   logic                   reset_start_ff;
   logic                   resume_start_ff;
   logic                   resume_event_ff;
   logic                   connect_change_ff;
   logic                   enable_change_ff;
   logic                   suspend_change_ff;
   logic                   nxt_attached;
   logic                   nxt_enabled;
   logic                   nxt_suspended;
   logic                   nxt_resetting;
   logic                   nxt_reset_start;
   logic                   nxt_resume_start;
   logic                   nxt_resume_event;
   logic                   nxt_connect_change;
   logic                   nxt_enable_change;
   logic                   nxt_suspend_change;
   logic                   port_wr;
   logic                   wr_disable;
   logic                   wr_enable;
   logic                   wr_suspend;
   logic                   wr_resume;
   logic                   wr_reset;
   logic                   disconnect;
   logic                   hw_disable;
   logic                   resume_done;
   logic                   reject;
   logic [EVENT_COUNT-1:0] events;

   rhps_apb_slave #(.AW(AW)) u_apb (
      .clk_in      (CLK_IN),
      .nrst_in     (NRST_IN),
      .psel_in     (PSEL_IN),
      .penable_in  (PENABLE_IN),
      .pwrite_in   (PWRITE_IN),
      .paddr_in    (PADDR_IN),
      .pwdata_in   (PWDATA_IN),
      .prdata_out  (PRDATA_OUT),
      .pready_out  (PREADY_OUT),
      .pslverr_out (PSLVERR_OUT),
      .rif         (rif.slave)
   );

   rhps_irq #(.EW(EVENT_COUNT)) u_irq (
      .clk_in    (CLK_IN),
      .nrst_in   (NRST_IN),
      .events_in (events),
      .irq_out   (IRQ_OUT),
      .rif       (rif.irq)
   );

   // port register write commands, one-to-act
   assign port_wr    = rif.wr_en
                     && rif.addr == AW'(PORT_REG_OFFSET);
   assign wr_disable = port_wr & rif.wdata[DISABLE_BIT];    // see (R12)
   assign wr_enable  = port_wr & rif.wdata[ENABLED_BIT];    // see (R9)
   assign wr_suspend = port_wr & rif.wdata[SUSPENDED_BIT];  // see (R1)
   assign wr_resume  = port_wr & rif.wdata[RESUME_REQ_BIT];
   assign wr_reset   = port_wr & rif.wdata[RESET_BIT];

   // attachment comes from the pin or the fixed-device mask only
   assign nxt_attached = ATTACH_IN | NONREMOVABLE_IN;  // see (R13) (R14)
   assign disconnect   = attached_ff & ~nxt_attached;

   // hardware reasons to drop the enable
   assign hw_disable = OVERCURRENT_IN | POWER_OFF_IN    // see (R6)
                     | BUS_ERROR_IN | disconnect;

   // resume completes only for a port that was suspended
   assign resume_done = RESUME_DONE_IN & suspended_ff;

   // suspend, enable and reset writes aimed at a detached port are turned away
   // judged on the registered attach, one cycle behind the pin
   assign reject = ~attached_ff                    // see (R2) (R10) (R15)
                 & (wr_suspend | wr_enable | wr_reset);

   always_ff @(posedge CLK_IN)
   begin
      if (!NRST_IN)
         attached_ff <= 1'b0;
      else
         attached_ff <= nxt_attached;                // see (R13)
   end

   // hardware disable outranks every set source
   // reset or resume done sets the enable even on a detached port
   always_comb
   begin
      nxt_enabled = enabled_ff;
      if (hw_disable)
         nxt_enabled = 1'b0;                         // see (R6) (R16)
      else if (RESET_DONE_IN | resume_done)
         nxt_enabled = 1'b1;                         // see (R8)
      else if (wr_disable)
         nxt_enabled = 1'b0;                         // see (R12)
      else if (wr_enable & attached_ff)
         nxt_enabled = 1'b1;                         // see (R9) (R10)
   end

   always_ff @(posedge CLK_IN)
   begin
      if (!NRST_IN)
         enabled_ff <= 1'b0;
      else
         enabled_ff <= nxt_enabled;                  // see (R16)
   end

   // clears from hardware beat a suspend write in the same cycle
   // a detach leaves suspend set until one of these clears it
   always_comb
   begin
      nxt_suspended = suspended_ff;
      if (resume_done)
         nxt_suspended = 1'b0;                       // see (R3)
      else if (RESET_DONE_IN | CONTROLLER_RESUME_IN)
         nxt_suspended = 1'b0;                       // see (R4)
      else if (wr_suspend & attached_ff)
         nxt_suspended = 1'b1;                       // see (R1) (R2)
   end

   always_ff @(posedge CLK_IN)
   begin
      if (!NRST_IN)
         suspended_ff <= 1'b0;
      else
         suspended_ff <= nxt_suspended;              // see (R16)
   end

   // reset in progress until the sequencer reports completion
   always_comb
   begin
      nxt_resetting = resetting_ff;
      if (RESET_DONE_IN)
         nxt_resetting = 1'b0;
      else if (wr_reset & attached_ff)
         nxt_resetting = 1'b1;                       // see (R15)
   end

   always_ff @(posedge CLK_IN)
   begin
      if (!NRST_IN)
         resetting_ff <= 1'b0;
      else
         resetting_ff <= nxt_resetting;
   end

   // pulse causes; a reset write while resetting starts nothing new
   always_comb
   begin
      nxt_reset_start    = wr_reset & attached_ff & ~resetting_ff;
      nxt_resume_start   = wr_resume & suspended_ff;
      nxt_resume_event   = DEVICE_RESUME_IN & suspended_ff;
      nxt_connect_change = reject | (attached_ff ^ nxt_attached);
      nxt_enable_change  = hw_disable & enabled_ff;
      nxt_suspend_change = resume_done;
   end

   always_ff @(posedge CLK_IN)
   begin
      if (!NRST_IN)
         reset_start_ff <= 1'b0;
      else
         reset_start_ff <= nxt_reset_start;          // see (R15)
   end

   // a resume request on a port that is not suspended is ignored
   always_ff @(posedge CLK_IN)
   begin
      if (!NRST_IN)
         resume_start_ff <= 1'b0;
      else
         resume_start_ff <= nxt_resume_start;
   end

   // remote wake from the downstream device
   always_ff @(posedge CLK_IN)
   begin
      if (!NRST_IN)
         resume_event_ff <= 1'b0;
      else
         resume_event_ff <= nxt_resume_event;        // see (R5)
   end

   // connect change: real attach or detach, or a turned-away write
   always_ff @(posedge CLK_IN)
   begin
      if (!NRST_IN)
         connect_change_ff <= 1'b0;
      else
         connect_change_ff <= nxt_connect_change;    // see (R2) (R10)
   end

   // only a real drop of the enable is reported
   always_ff @(posedge CLK_IN)
   begin
      if (!NRST_IN)
         enable_change_ff <= 1'b0;
      else
         enable_change_ff <= nxt_enable_change;      // see (R7)
   end

   always_ff @(posedge CLK_IN)
   begin
      if (!NRST_IN)
         suspend_change_ff <= 1'b0;
      else
         suspend_change_ff <= nxt_suspend_change;    // see (R3)
   end

   // read view of the port register
   always_comb
   begin
      rif.port_value                 = 32'h0000_0000;
      rif.port_value[ATTACHED_BIT]   = attached_ff;  // see (R11) (R14)
      rif.port_value[ENABLED_BIT]    = enabled_ff;
      rif.port_value[SUSPENDED_BIT]  = suspended_ff;
      rif.port_value[RESET_BIT]      = resetting_ff;
   end

   // events reach the status register a cycle after their cause, except reset done, which goes straight in
   always_comb
   begin
      events              = '0;
      events[EV_CONNECT]  = connect_change_ff;
      events[EV_ENABLE]   = enable_change_ff;
      events[EV_SUSPEND]  = suspend_change_ff;
      events[EV_RESET]    = RESET_DONE_IN;
      events[EV_RESUME]   = resume_event_ff;
   end

   assign DEVICE_ATTACHED_OUT = attached_ff;
   assign PORT_ENABLED_OUT    = enabled_ff;
   assign PORT_SUSPENDED_OUT  = suspended_ff;
   assign PORT_RESETTING_OUT  = resetting_ff;
   assign RESET_START_OUT     = reset_start_ff;
   assign RESUME_START_OUT    = resume_start_ff;
   assign RESUME_EVENT_OUT    = resume_event_ff;
   assign CONNECT_CHANGE_OUT  = connect_change_ff;
   assign ENABLE_CHANGE_OUT   = enable_change_ff;
   assign SUSPEND_CHANGE_OUT  = suspend_change_ff;
endmodule : rhps_port_top

// >>> verification/rhps_dev_model.sv
// attached usb device model: plug state and remote wake
// assumes the bench commands it just after rising edges
module rhps_dev_model
(
   input  wire logic clk_in,
   input  wire logic plug_in,
   input  wire logic wake_in,
   output logic      attach_out,
   output logic      resume_out
);
   timeunit 1ns;
   timeprecision 1ns;
   logic attach_ff;
   logic wake_ff;
   // one edge of cable delay; no wake once unplugged
   always_ff @(posedge clk_in)
   begin
      attach_ff <= plug_in;
      wake_ff   <= wake_in & plug_in;
   end
   assign attach_out = attach_ff;
   assign resume_out = wake_ff;
endmodule : rhps_dev_model

// >>> verification/rhps_port_assertions.sv
// port state checker on the top module ports
// assumes one clock domain and synchronous active low reset
module rhps_port_assertions
   import rhps_pkg::*;
#(
   parameter int AW = 8
)(
   input wire logic          CLK_IN,
   input wire logic          NRST_IN,
   input wire logic          PSEL_IN,
   input wire logic          PENABLE_IN,
   input wire logic          PWRITE_IN,
   input wire logic [AW-1:0] PADDR_IN,
   input wire logic [31:0]   PWDATA_IN,
   input wire logic          ATTACH_IN,
   input wire logic          NONREMOVABLE_IN,
   input wire logic          OVERCURRENT_IN,
   input wire logic          POWER_OFF_IN,
   input wire logic          BUS_ERROR_IN,
   input wire logic          RESET_DONE_IN,
   input wire logic          RESUME_DONE_IN,
   input wire logic          CONTROLLER_RESUME_IN,
   input wire logic          DEVICE_RESUME_IN,
   input wire logic          DEVICE_ATTACHED_OUT,
   input wire logic          PORT_ENABLED_OUT,
   input wire logic          PORT_SUSPENDED_OUT,
   input wire logic          RESUME_EVENT_OUT,
   input wire logic          CONNECT_CHANGE_OUT,
   input wire logic          ENABLE_CHANGE_OUT,
   input wire logic          SUSPEND_CHANGE_OUT
);
   default clocking cb @(posedge CLK_IN);
   endclocking
   default disable iff (!NRST_IN);
   logic wr_port;
   logic hw_off;
   logic pin_on;
   assign wr_port = PSEL_IN & PENABLE_IN & PWRITE_IN &
                    (PADDR_IN == AW'(PORT_REG_OFFSET));
   assign hw_off = OVERCURRENT_IN | POWER_OFF_IN | BUS_ERROR_IN;
   // disconnect may be seen from the pin or the flag, so both
   assign pin_on = DEVICE_ATTACHED_OUT & (ATTACH_IN | NONREMOVABLE_IN);
   AST_ATTACH: assert property ($past(NRST_IN) |->
      DEVICE_ATTACHED_OUT == $past(ATTACH_IN | NONREMOVABLE_IN))
      else $error("attached flag off the pin");
   AST_HW_OFF: assert property (PORT_ENABLED_OUT && hw_off
      |=> !PORT_ENABLED_OUT && ENABLE_CHANGE_OUT)
      else $error("hardware disable missed");
   AST_HW_WINS: assert property (wr_port && PWDATA_IN[1] && hw_off
      |=> !PORT_ENABLED_OUT) else $error("software enable beat fault");
   AST_RST_DONE: assert property (RESET_DONE_IN && !hw_off
      && pin_on |=> PORT_ENABLED_OUT && !PORT_SUSPENDED_OUT)
      else $error("reset done flags wrong");
   AST_RES_DONE: assert property (RESUME_DONE_IN
      && PORT_SUSPENDED_OUT |=> !PORT_SUSPENDED_OUT && SUSPEND_CHANGE_OUT)
      else $error("resume end flags wrong");
   AST_CTRL_RES: assert property (CONTROLLER_RESUME_IN
      |=> !PORT_SUSPENDED_OUT) else $error("suspend kept in resume");
   AST_DEV_RES: assert property (DEVICE_RESUME_IN
      && PORT_SUSPENDED_OUT |=> RESUME_EVENT_OUT)
      else $error("resume not passed up");
   AST_SW_SUSP: assert property (wr_port && PWDATA_IN[2] &&
      DEVICE_ATTACHED_OUT && !(RESUME_DONE_IN | RESET_DONE_IN |
      CONTROLLER_RESUME_IN) |=> PORT_SUSPENDED_OUT)
      else $error("suspend write lost");
   AST_DETACHED: assert property (wr_port && |PWDATA_IN[2:1]
      && !DEVICE_ATTACHED_OUT |=> CONNECT_CHANGE_OUT)
      else $error("no connect change on detached write");
   AST_SW_OFF: assert property (wr_port && PWDATA_IN[0] &&
      !(RESET_DONE_IN | RESUME_DONE_IN) |=> !PORT_ENABLED_OUT)
      else $error("disable write lost");
   AST_SW_ON: assert property (wr_port && PWDATA_IN[1:0] == 2'h2 &&
      pin_on && !hw_off |=> PORT_ENABLED_OUT)
      else $error("enable write lost");
   cover property (wr_port && PWDATA_IN[2] && DEVICE_ATTACHED_OUT);
   cover property (RESUME_DONE_IN && PORT_SUSPENDED_OUT);
   cover property (PORT_ENABLED_OUT && hw_off);
endmodule : rhps_port_assertions

bind rhps_port_top rhps_port_assertions #(.AW(AW)) u_chk (.*);

// >>> verification/testbench.sv
// self-checking bench for the root hub port state block
// assumes the device model on the port side, apb from here
module testbench
   import rhps_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_in = 1'b0, nrst_in = 1'b0, plug = 1'b0, wake = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, nonrem = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, rd, prdata;
   logic [5:0] ev = 6'h00;
   logic attach, dres, slverr, pready, pslverr, attached, enabled;
   logic suspended, rst_go, res_ev, conn_chg, en_chg, susp_chg, irq;
   logic resetting, res_go;
   int error_cnt = 0;
   int compares = 0;
   always #20 clk_in = ~clk_in;
   rhps_dev_model dev (.clk_in(clk_in), .plug_in(plug), .wake_in(wake),
      .attach_out(attach), .resume_out(dres));
   rhps_port_top #(.AW(8)) dut (.CLK_IN(clk_in), .NRST_IN(nrst_in),
      .PSEL_IN(psel), .PENABLE_IN(penable), .PWRITE_IN(pwrite),
      .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
      .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .ATTACH_IN(attach),
      .NONREMOVABLE_IN(nonrem), .OVERCURRENT_IN(ev[0]),
      .POWER_OFF_IN(ev[1]), .BUS_ERROR_IN(ev[2]), .RESET_DONE_IN(ev[3]),
      .RESUME_DONE_IN(ev[4]), .CONTROLLER_RESUME_IN(ev[5]),
      .DEVICE_RESUME_IN(dres), .DEVICE_ATTACHED_OUT(attached),
      .PORT_ENABLED_OUT(enabled), .PORT_SUSPENDED_OUT(suspended),
      .PORT_RESETTING_OUT(resetting), .RESET_START_OUT(rst_go),
      .RESUME_START_OUT(res_go), .RESUME_EVENT_OUT(res_ev),
      .CONNECT_CHANGE_OUT(conn_chg), .ENABLE_CHANGE_OUT(en_chg),
      .SUSPEND_CHANGE_OUT(susp_chg), .IRQ_OUT(irq));

   task automatic tally_and_finish();
      $display("compares %0d mismatches %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : tally_and_finish

   task automatic chk(input logic [31:0] got, exp, input int id);
      compares++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("wrong value at %0t: check %0d got %h", $time, id, got);
      end
   endtask : chk

   // starts and ends at a falling edge, where outputs are settled
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_in);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_in);
      penable <= 1'b1;
      do
      begin
         @(posedge clk_in);
         n++;
      end
      while (pready !== 1'b1 && n < 16);
      if (pready !== 1'b1)
      begin
         error_cnt++;
         $display("wrong value at %0t: apb wait ran out", $time);
         tally_and_finish();
      end
      rd = prdata;
      slverr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(negedge clk_in);
   endtask : apb

   task automatic rchk(input logic [7:0] a, input logic [31:0] e,
                       input int id);
      apb(1'b0, a, 32'h0);
      chk(rd, e, id);
   endtask : rchk

   task automatic idle(input int n);
      repeat (n) @(posedge clk_in);
      @(negedge clk_in);
   endtask : idle

   task automatic pulse(input logic [5:0] m);
      @(posedge clk_in);
      ev <= m;
      @(posedge clk_in);
      ev <= 6'h00;
      @(negedge clk_in);
   endtask : pulse

   initial
   begin
      repeat (20) @(posedge clk_in);
      nrst_in <= 1'b1;
      @(negedge clk_in);
      rchk(PORT_REG_OFFSET, 32'h0, 1);
      rchk(IRQ_STATUS_OFFSET, 32'h0, 2);
      rchk(IRQ_ENABLE_OFFSET, 32'h0, 3);
      rchk(IRQ_CLEAR_OFFSET, 32'h0, 4);
      rchk(8'h10, 32'h0, 5);
      chk(slverr, 1'b1, 6);
      apb(1'b1, PORT_REG_OFFSET, 32'h6);
      chk({conn_chg, suspended, enabled}, 3'b100, 7);
      apb(1'b1, PORT_REG_OFFSET, 32'h10);
      chk({conn_chg, rst_go, resetting}, 3'b100, 8);
      $display("test registers and detached port done");
      @(posedge clk_in);
      plug <= 1'b1;
      idle(4);
      apb(1'b1, PORT_REG_OFFSET, 32'h1);
      apb(1'b1, PORT_REG_OFFSET, 32'h0);
      rchk(PORT_REG_OFFSET, 32'h1, 9);
      apb(1'b1, PORT_REG_OFFSET, 32'h2);
      apb(1'b1, PORT_REG_OFFSET, 32'h0);
      chk(enabled, 1'b1, 10);
      apb(1'b1, PORT_REG_OFFSET, 32'h1);
      chk({enabled, attached}, 2'b01, 11);
      apb(1'b1, PORT_REG_OFFSET, 32'h2);
      apb(1'b1, PORT_REG_OFFSET, 32'h4);
      rchk(PORT_REG_OFFSET, 32'h7, 12);
      @(posedge clk_in);
      wake <= 1'b1;
      idle(3);
      chk(res_ev, 1'b1, 13);
      @(posedge clk_in);
      wake <= 1'b0;
      // disabled first so the hardware enable can be seen
      apb(1'b1, PORT_REG_OFFSET, 32'h1);
      pulse(6'h10);
      chk({susp_chg, suspended, enabled}, 3'b101, 14);
      apb(1'b1, PORT_REG_OFFSET, 32'h5);
      apb(1'b1, PORT_REG_OFFSET, 32'h10);
      chk({resetting, rst_go}, 2'b11, 15);
      apb(1'b1, PORT_REG_OFFSET, 32'h10);
      chk({resetting, rst_go}, 2'b10, 31);
      rchk(PORT_REG_OFFSET, 32'h15, 32);
      pulse(6'h08);
      chk({resetting, suspended, enabled}, 3'b001, 16);
      apb(1'b1, PORT_REG_OFFSET, 32'h4);
      apb(1'b1, PORT_REG_OFFSET, 32'h8);
      chk(res_go, 1'b1, 33);
      pulse(6'h20);
      chk(suspended, 1'b0, 17);
      apb(1'b1, PORT_REG_OFFSET, 32'h8);
      chk({res_go, suspended}, 2'b00, 34);
      $display("test suspend resume reset done");
      for (int i = 0; i < 3; i++)
      begin
         apb(1'b1, PORT_REG_OFFSET, 32'h2);
         pulse(6'h01 << i);
         chk({en_chg, enabled}, 2'b10, 18 + i);
      end
      @(posedge clk_in);
      ev <= 6'h01;
      apb(1'b1, PORT_REG_OFFSET, 32'h2);
      chk(enabled, 1'b0, 21);
      @(posedge clk_in);
      ev <= 6'h00;
      $display("test hardware disable done");
      chk(irq, 1'b0, 22);
      rchk(IRQ_STATUS_OFFSET, 32'h1f, 23);
      apb(1'b1, IRQ_ENABLE_OFFSET, 32'h2);
      chk(irq, 1'b1, 24);
      apb(1'b1, IRQ_CLEAR_OFFSET, 32'h1f);
      chk(irq, 1'b0, 25);
      rchk(IRQ_STATUS_OFFSET, 32'h0, 26);
      apb(1'b1, PORT_REG_OFFSET, 32'h2);
      pulse(6'h02);
      idle(1);
      chk(irq, 1'b1, 27);
      apb(1'b1, IRQ_ENABLE_OFFSET, 32'h0);
      chk(irq, 1'b0, 28);
      $display("test interrupts done");
      apb(1'b1, PORT_REG_OFFSET, 32'h2);
      @(posedge clk_in);
      plug <= 1'b0;
      idle(4);
      chk({attached, enabled}, 2'b00, 29);
      @(posedge clk_in);
      nonrem <= 1'b1;
      idle(2);
      rchk(PORT_REG_OFFSET, 32'h1, 30);
      $display("test disconnect done");
      tally_and_finish();
   end
endmodule : testbench
